// ==== adc_output_formatter_consts.svh ====
// Constants for the converter output formatter: offsets, field positions,
// reset values and timing counts. Assumes a 25 MHz core clock.
`ifndef ADC_OUTPUT_FORMATTER_CONSTS_SVH
`define ADC_OUTPUT_FORMATTER_CONSTS_SVH

// ==========================================================================
// Widths and pipeline
`define AOF_DATA_W        16
`define AOF_LATENCY       4
`define AOF_ADDR_W        4
`define AOF_REG_W         32
`define AOF_EV_W          5

// ==========================================================================
// Register offsets
`define AOF_REG_CTRL      4'h0
`define AOF_REG_STATUS    4'h4
`define AOF_REG_MASK      4'h8
`define AOF_REG_STATE     4'hc

// ==========================================================================
// Field positions and reset values
`define AOF_CTRL_DITHER   0
`define AOF_EV_OFA        0
`define AOF_EV_OFB        1
`define AOF_EV_OFL        2
`define AOF_EV_LOST       3
`define AOF_EV_LOCK       4
`define AOF_CTRL_RST      1'b0
`define AOF_MASK_RST      5'h00
`define AOF_LFSR_SEED     16'h0001

// ==========================================================================
// Timing
`define AOF_CLK_PERIOD_NS 40
`define AOF_STOP_TIME_NS  2560
`define AOF_STOP_CYCLES   (`AOF_STOP_TIME_NS / `AOF_CLK_PERIOD_NS)
`define AOF_RELOCK_EDGES  7'd100

`endif

// ==== adc_output_formatter_pkg.sv ====
// Types for the converter output formatter.
// Assumes adc_output_formatter_consts.svh is compiled alongside.
package adc_output_formatter_pkg;

    // ======================================================================
    // Output mode, from the four-level mode pin
    typedef enum logic [1:0]
    {
        MODE_CMOS_FULL  = 2'b00,
        MODE_CMOS_DEMUX = 2'b01,
        MODE_LVDS_LOW   = 2'b10,
        MODE_LVDS_STD   = 2'b11
    } out_mode_e;

    // ======================================================================
    // Format pin, both format and stabilizer
    typedef enum logic [1:0]
    {
        FMT_OB_STAB_OFF = 2'b00,
        FMT_OB_STAB_ON  = 2'b01,
        FMT_TC_STAB_ON  = 2'b10,
        FMT_TC_STAB_OFF = 2'b11
    } format_e;

    typedef logic [15:0] word_t;

endpackage : adc_output_formatter_pkg

// ==== adc_output_formatter.sv ====
// Digital output stage of a 16-bit pipelined converter: mode decode, format,
// dither removal, scrambling, over-range flags and output clocks.
// Assumes pins arrive asynchronously and the strobe is far slower than CLOCK.
`timescale 1ns/1ps
`include "adc_output_formatter_consts.svh"

module adc_output_formatter
(
    input  wire logic                     CLOCK,
    input  wire logic                     NRST,
    input  wire logic                     CE,
    input  wire logic                     SAMPLE_STROBE_INPUT,
    input  wire logic [1:0]               OUTPUT_MODE_PIN,
    input  wire logic [1:0]               FORMAT_PIN,
    input  wire logic                     SCRAMBLE_ENABLE_PIN,
    input  wire logic [`AOF_DATA_W-1:0]   CORE_RESULT,
    input  wire logic                     CORE_OVER_RANGE,
    input  wire logic [`AOF_ADDR_W-1:0]   ADDR,
    input  wire logic [`AOF_REG_W-1:0]    WDATA,
    input  wire logic                     WR,
    input  wire logic                     RD,
    output logic      [`AOF_REG_W-1:0]    RDATA,
    output logic                          IRQ,
    output logic      [`AOF_DATA_W-1:0]   BUS_A_DATA,
    output logic      [`AOF_DATA_W-1:0]   BUS_B_DATA,
    output logic                          OVERFLOW_FLAG_BUS_A,
    output logic                          OVERFLOW_FLAG_BUS_B,
    output logic                          OVERFLOW_FLAG,
    output logic                          FORWARDED_SAMPLE_CLOCK,
    output logic                          BUS_A_OUTPUT_CLOCK,
    output logic                          BUS_B_OUTPUT_CLOCK,
    output logic                          LVDS_SELECT,
    output logic                          LVDS_LOW_POWER,
    output logic                          STABILIZER_ON,
    output logic                          STABILIZER_LOCKED,
    output logic      [`AOF_DATA_W-1:0]   DITHER_VALUE
);

    // ======================================================================
    // Input synchronisers
    logic [2:0]                 strobe_sync;
    logic [1:0]                 mode_s1;
    logic [1:0]                 mode_s2;
    logic [1:0]                 fmt_s1;
    logic [1:0]                 fmt_s2;
    logic [1:0]                 scr_sync;
    logic [`AOF_DATA_W-1:0]     res_s1;
    logic [`AOF_DATA_W-1:0]     res_s2;
    logic [1:0]                 ovr_sync;

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            strobe_sync <= 3'h0;
            mode_s1     <= 2'h0;
            mode_s2     <= 2'h0;
            fmt_s1      <= 2'h0;
            fmt_s2      <= 2'h0;
            scr_sync    <= 2'h0;
            res_s1      <= 16'h0000;
            res_s2      <= 16'h0000;
            ovr_sync    <= 2'h0;
        end
        else if (CE)
        begin
            strobe_sync <= {strobe_sync[1:0], SAMPLE_STROBE_INPUT};
            mode_s1     <= OUTPUT_MODE_PIN;
            mode_s2     <= mode_s1;
            fmt_s1      <= FORMAT_PIN;
            fmt_s2      <= fmt_s1;
            scr_sync    <= {scr_sync[0], SCRAMBLE_ENABLE_PIN};
            res_s1      <= CORE_RESULT;
            res_s2      <= res_s1;
            ovr_sync    <= {ovr_sync[0], CORE_OVER_RANGE};
        end
    end

    // Only the rising strobe edge samples; the falling edge is ignored
    logic                              tick;
    adc_output_formatter_pkg::out_mode_e mode;
    adc_output_formatter_pkg::format_e   fmt;
    logic                              twos_comp;
    logic                              stab_req;
    logic                              demux;
    logic                              lvds;

    assign tick      = strobe_sync[1] & ~strobe_sync[2];
    assign mode      = adc_output_formatter_pkg::out_mode_e'(mode_s2);
    assign fmt       = adc_output_formatter_pkg::format_e'(fmt_s2);
    assign twos_comp = (fmt == adc_output_formatter_pkg::FMT_TC_STAB_ON) ||
                       (fmt == adc_output_formatter_pkg::FMT_TC_STAB_OFF);
    assign stab_req  = (fmt == adc_output_formatter_pkg::FMT_OB_STAB_ON) ||
                       (fmt == adc_output_formatter_pkg::FMT_TC_STAB_ON);
    assign demux     = (mode == adc_output_formatter_pkg::MODE_CMOS_DEMUX);
    assign lvds      = (mode == adc_output_formatter_pkg::MODE_LVDS_LOW) ||
                       (mode == adc_output_formatter_pkg::MODE_LVDS_STD);

    // ======================================================================
    // Registers
    logic                       dither_en;
    logic [`AOF_EV_W-1:0]       status;
    logic [`AOF_EV_W-1:0]       mask;
    logic [`AOF_EV_W-1:0]       events;
    logic                       next_dither_en;
    logic [`AOF_EV_W-1:0]       next_status;
    logic [`AOF_EV_W-1:0]       next_mask;
    logic [`AOF_REG_W-1:0]      next_rdata;
    logic                       next_irq;

    always_comb
    begin
        next_dither_en = dither_en;
        next_mask      = mask;
        next_rdata     = 32'h0000_0000;
        // A new event wins over a clear in the same cycle
        next_status    = status | events;
        if (WR)
        begin
            case (ADDR)
                `AOF_REG_CTRL:   next_dither_en = WDATA[`AOF_CTRL_DITHER];
                `AOF_REG_STATUS: next_status = (status & ~WDATA[`AOF_EV_W-1:0]) | events;
                `AOF_REG_MASK:   next_mask = WDATA[`AOF_EV_W-1:0];
                default:         next_mask = mask;
            endcase
        end
        if (RD)
        begin
            case (ADDR)
                `AOF_REG_CTRL:   next_rdata = {31'h0, dither_en};
                `AOF_REG_STATUS: next_rdata = {27'h0, status};
                `AOF_REG_MASK:   next_rdata = {27'h0, mask};
                `AOF_REG_STATE:  next_rdata = {25'h0, STABILIZER_LOCKED, stab_req,
                                               scr_sync[1], fmt_s2, mode_s2};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            dither_en <= `AOF_CTRL_RST;
            status    <= 5'h00;
            mask      <= `AOF_MASK_RST;
            RDATA     <= 32'h0000_0000;
            IRQ       <= 1'b0;
        end
        else if (CE)
        begin
            dither_en <= next_dither_en;
            status    <= next_status;
            mask      <= next_mask;
            RDATA     <= next_rdata;
            IRQ       <= next_irq;
        end
    end

    // ======================================================================
    // Stabilizer lock tracking
    logic [11:0]                idle_cnt;
    logic [6:0]                 relock_cnt;
    logic [11:0]                next_idle_cnt;
    logic [6:0]                 next_relock_cnt;
    logic                       next_locked;
    logic                       ev_lost;
    logic                       ev_lock;

    always_comb
    begin
        next_idle_cnt   = idle_cnt;
        next_relock_cnt = relock_cnt;
        next_locked     = STABILIZER_LOCKED;
        ev_lost         = 1'b0;
        ev_lock         = 1'b0;
        if (tick)
            next_idle_cnt = 12'h000;
        else if (idle_cnt != 12'(`AOF_STOP_CYCLES))
            next_idle_cnt = idle_cnt + 12'h001;
        if (!stab_req)
        begin
            next_locked     = 1'b1;
            next_relock_cnt = 7'h00;
        end
        else if (!tick && idle_cnt == 12'(`AOF_STOP_CYCLES) - 12'h001)
        begin
            // A long stoppage drops lock; a fresh count is then needed
            ev_lost         = STABILIZER_LOCKED;
            next_locked     = 1'b0;
            next_relock_cnt = 7'h00;
        end
        else if (!STABILIZER_LOCKED && tick)
        begin
            next_relock_cnt = relock_cnt + 7'h01;
            if (next_relock_cnt == `AOF_RELOCK_EDGES)
            begin
                next_locked = 1'b1;
                ev_lock     = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            idle_cnt          <= 12'h000;
            relock_cnt        <= 7'h00;
            STABILIZER_LOCKED <= 1'b1;
        end
        else if (CE)
        begin
            idle_cnt          <= next_idle_cnt;
            relock_cnt        <= next_relock_cnt;
            STABILIZER_LOCKED <= next_locked;
        end
    end

    // ======================================================================
    // Dither generator and removal, then the latency pipeline
    logic [`AOF_DATA_W-1:0]     lfsr;
    logic [`AOF_DATA_W-1:0]     next_lfsr;
    logic [`AOF_DATA_W-1:0]     corrected;
    logic [`AOF_DATA_W-1:0]     pipe_word [0:`AOF_LATENCY-1];
    logic                       pipe_over [0:`AOF_LATENCY-1];

    always_comb
    begin
        next_lfsr = lfsr;
        if (tick && dither_en)
            next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        // The same value sent to the dither converter is taken off here
        corrected = dither_en ? (res_s2 - DITHER_VALUE) : res_s2;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            lfsr         <= `AOF_LFSR_SEED;
            DITHER_VALUE <= 16'h0000;
            pipe_word[0] <= 16'h0000;
            pipe_over[0] <= 1'b0;
        end
        else if (CE)
        begin
            lfsr         <= next_lfsr;
            DITHER_VALUE <= dither_en ? next_lfsr : 16'h0000;
            if (tick)
            begin
                pipe_word[0] <= corrected;
                pipe_over[0] <= ovr_sync[1];
            end
        end
    end

    genvar g;
    generate
        for (g = 1; g < `AOF_LATENCY; g = g + 1)
        begin : g_pipe
            always_ff @(posedge CLOCK or negedge NRST)
            begin
                if (!NRST)
                begin
                    pipe_word[g] <= 16'h0000;
                    pipe_over[g] <= 1'b0;
                end
                else if (CE && tick)
                begin
                    pipe_word[g] <= pipe_word[g-1];
                    pipe_over[g] <= pipe_over[g-1];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Format, scramble, bus steering and output clocks
    logic [`AOF_DATA_W-1:0]     out_word;
    logic                       out_over;
    logic [`AOF_DATA_W-1:0]     hold_word;
    logic                       hold_over;
    logic                       phase;
    logic [`AOF_DATA_W-1:0]     next_hold_word;
    logic                       next_hold_over;
    logic                       next_phase;
    logic [`AOF_DATA_W-1:0]     next_bus_a;
    logic [`AOF_DATA_W-1:0]     next_bus_b;
    logic                       next_ofa;
    logic                       next_ofb;
    logic                       next_of;
    logic                       next_clk_a;
    logic                       next_clk_b;

    always_comb
    begin
        out_word = pipe_word[`AOF_LATENCY-1];
        out_over = pipe_over[`AOF_LATENCY-1];
        if (twos_comp)
            out_word[`AOF_DATA_W-1] = ~out_word[`AOF_DATA_W-1];
        // Flags and clocks never pass through this XOR
        if (scr_sync[1])
            out_word[`AOF_DATA_W-1:1] = out_word[`AOF_DATA_W-1:1] ^
                                        {(`AOF_DATA_W-1){out_word[0]}};
        next_hold_word = hold_word;
        next_hold_over = hold_over;
        next_phase     = phase;
        next_bus_a     = BUS_A_DATA;
        next_bus_b     = BUS_B_DATA;
        next_ofa       = OVERFLOW_FLAG_BUS_A;
        next_ofb       = OVERFLOW_FLAG_BUS_B;
        next_of        = OVERFLOW_FLAG;
        next_clk_a     = BUS_A_OUTPUT_CLOCK;
        next_clk_b     = BUS_B_OUTPUT_CLOCK;
        events         = 5'h00;
        if (!demux)
        begin
            // Clock A is the inverted strobe, so data moves as it falls
            next_clk_a = ~strobe_sync[1];
            next_clk_b = strobe_sync[1];
            next_phase = 1'b0;
        end
        // Flags of the other standard drop with the mode, not a tick later
        if (lvds)
        begin
            next_ofa = 1'b0;
            next_ofb = 1'b0;
        end
        else
            next_of = 1'b0;
        if (tick)
        begin
            case (mode)
                adc_output_formatter_pkg::MODE_CMOS_FULL:
                begin
                    next_bus_a = out_word;
                    next_bus_b = 16'h0000;
                    next_ofa   = out_over;
                    next_ofb   = 1'b0;
                    next_of    = 1'b0;
                    events[`AOF_EV_OFA] = out_over;
                end
                adc_output_formatter_pkg::MODE_CMOS_DEMUX:
                begin
                    next_phase = ~phase;
                    next_clk_a = ~phase;
                    next_clk_b = phase;
                    next_of    = 1'b0;
                    if (!phase)
                    begin
                        next_hold_word = out_word;
                        next_hold_over = out_over;
                    end
                    else
                    begin
                        // Older sample on A, newer on B, both as clock A falls
                        next_bus_a = hold_word;
                        next_bus_b = out_word;
                        next_ofa   = hold_over;
                        next_ofb   = out_over;
                        events[`AOF_EV_OFA] = hold_over;
                        events[`AOF_EV_OFB] = out_over;
                    end
                end
                default:
                begin
                    next_bus_a = out_word;
                    next_bus_b = 16'h0000;
                    next_ofa   = 1'b0;
                    next_ofb   = 1'b0;
                    next_of    = out_over;
                    events[`AOF_EV_OFL] = out_over;
                end
            endcase
        end
        events[`AOF_EV_LOST] = ev_lost;
        events[`AOF_EV_LOCK] = ev_lock;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            hold_word              <= 16'h0000;
            hold_over              <= 1'b0;
            phase                  <= 1'b0;
            BUS_A_DATA             <= 16'h0000;
            BUS_B_DATA             <= 16'h0000;
            OVERFLOW_FLAG_BUS_A    <= 1'b0;
            OVERFLOW_FLAG_BUS_B    <= 1'b0;
            OVERFLOW_FLAG          <= 1'b0;
            BUS_A_OUTPUT_CLOCK     <= 1'b1;
            BUS_B_OUTPUT_CLOCK     <= 1'b0;
            FORWARDED_SAMPLE_CLOCK <= 1'b0;
            LVDS_SELECT            <= 1'b0;
            LVDS_LOW_POWER         <= 1'b0;
            STABILIZER_ON          <= 1'b0;
        end
        else if (CE)
        begin
            hold_word              <= next_hold_word;
            hold_over              <= next_hold_over;
            phase                  <= next_phase;
            BUS_A_DATA             <= next_bus_a;
            BUS_B_DATA             <= next_bus_b;
            OVERFLOW_FLAG_BUS_A    <= next_ofa;
            OVERFLOW_FLAG_BUS_B    <= next_ofb;
            OVERFLOW_FLAG          <= next_of;
            BUS_A_OUTPUT_CLOCK     <= next_clk_a;
            BUS_B_OUTPUT_CLOCK     <= next_clk_b;
            FORWARDED_SAMPLE_CLOCK <= strobe_sync[1];
            LVDS_SELECT            <= lvds;
            LVDS_LOW_POWER         <= (mode == adc_output_formatter_pkg::MODE_LVDS_LOW);
            STABILIZER_ON          <= stab_req;
        end
    end

endmodule : adc_output_formatter

// ==== adc_output_formatter_properties.sv ====
// Checker on the output formatter ports.
// Assumes a bind to the top module, with CE held high.
`timescale 1ns/1ps
`include "adc_output_formatter_consts.svh"

module adc_output_formatter_checker
(
    input wire logic                   CLOCK,
    input wire logic                   NRST,
    input wire logic                   SAMPLE_STROBE_INPUT,
    input wire logic [1:0]             OUTPUT_MODE_PIN,
    input wire logic [1:0]             FORMAT_PIN,
    input wire logic [`AOF_DATA_W-1:0] BUS_A_DATA,
    input wire logic [`AOF_DATA_W-1:0] BUS_B_DATA,
    input wire logic                   OVERFLOW_FLAG_BUS_A,
    input wire logic                   OVERFLOW_FLAG,
    input wire logic                   FORWARDED_SAMPLE_CLOCK,
    input wire logic                   BUS_A_OUTPUT_CLOCK,
    input wire logic                   BUS_B_OUTPUT_CLOCK,
    input wire logic                   LVDS_SELECT,
    input wire logic                   LVDS_LOW_POWER,
    input wire logic                   STABILIZER_ON
);
    // ======================================================================
    // Properties
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // Pins pass two sync stages and a decode register
    a_mode_decode: assert property ($stable(OUTPUT_MODE_PIN)[*4] |->
        LVDS_SELECT == OUTPUT_MODE_PIN[1] && LVDS_LOW_POWER == (OUTPUT_MODE_PIN == 2'h2)) else $error("mode decode");
    a_format_decode: assert property ($stable(FORMAT_PIN)[*4] |->
        STABILIZER_ON == (FORMAT_PIN == 2'h1 || FORMAT_PIN == 2'h2)) else $error("stabilizer decode");
    a_flag_split: assert property ($stable(LVDS_SELECT)[*3] |->
        (LVDS_SELECT ? !OVERFLOW_FLAG_BUS_A : !OVERFLOW_FLAG)) else $error("flag in wrong mode");
    a_fwd_rise: assert property ($rose(FORWARDED_SAMPLE_CLOCK) |-> $past(SAMPLE_STROBE_INPUT, 3))
        else $error("forwarded clock rise");
    a_fwd_fall: assert property ($fell(FORWARDED_SAMPLE_CLOCK) |-> !$past(SAMPLE_STROBE_INPUT, 3))
        else $error("forwarded clock fall");
    a_bus_a_edge: assert property (!LVDS_SELECT && $changed(BUS_A_DATA) |-> $fell(BUS_A_OUTPUT_CLOCK))
        else $error("bus a moved off edge");
    a_bus_b_edge: assert property ($changed(BUS_B_DATA) && BUS_B_DATA != 16'h0 |->
        $fell(BUS_A_OUTPUT_CLOCK) && $rose(BUS_B_OUTPUT_CLOCK)) else $error("bus b moved off edge");
    a_clocks_apart: assert property (!LVDS_SELECT |-> BUS_A_OUTPUT_CLOCK != BUS_B_OUTPUT_CLOCK)
        else $error("output clocks not opposite");
endmodule : adc_output_formatter_checker

// ==== capture_receiver.sv ====
// Capturing logic model beyond the sample buses.
// Assumes the bench says whether the buses arrive scrambled.
`timescale 1ns/1ps

module capture_receiver
(
    input  wire logic        clock_a,
    input  wire logic        descramble,
    input  wire logic [15:0] bus_a,
    input  wire logic [15:0] bus_b,
    output logic      [15:0] captured_a,
    output logic      [15:0] captured_b,
    output int               captures
);
    // ======================================================================
    // Capture on the rising bus A clock, half a period after data moved
    initial captures = 0;
    always @(posedge clock_a)
    begin
        captured_a <= descramble ? bus_a ^ {{15{bus_a[0]}}, 1'h0} : bus_a;
        captured_b <= descramble ? bus_b ^ {{15{bus_b[0]}}, 1'h0} : bus_b;
        captures   <= captures + 1;
    end
endmodule : capture_receiver

// ==== test_adc_output_formatter.sv ====
// Self-checking bench for the converter output formatter.
// Assumes the checker and the capture model are compiled before it.
`timescale 1ns/1ps

module test_adc_output_formatter;
    // ======================================================================
    // Signals
    logic        clock = 1'h0, nrst = 1'h0, strobe = 1'h0, run = 1'h0, counting = 1'h0;
    logic        scr = 1'h0, ovr = 1'h0, wr = 1'h0, rd = 1'h0;
    logic        irq, overflow_flag_bus_a, overflow_flag_bus_b, ofl, clk_a, lvds, lowp, stab, locked;
    logic [1:0]  mode = 2'h0, fmt = 2'h0;
    logic [2:0]  phase = 3'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [15:0] result = 16'h1235, bus_a, bus_b, cap_a, cap_b, dither;
    int          fail_count = 0, checked = 0, captures, c0;

    adc_output_formatter dut_u
    (
        .CLOCK(clock), .NRST(nrst), .CE(1'h1), .SAMPLE_STROBE_INPUT(strobe), .OUTPUT_MODE_PIN(mode),
        .FORMAT_PIN(fmt), .SCRAMBLE_ENABLE_PIN(scr), .CORE_RESULT(result), .CORE_OVER_RANGE(ovr),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .BUS_A_DATA(bus_a),
        .BUS_B_DATA(bus_b), .OVERFLOW_FLAG_BUS_A(overflow_flag_bus_a), .OVERFLOW_FLAG_BUS_B(overflow_flag_bus_b), .OVERFLOW_FLAG(ofl),
        .FORWARDED_SAMPLE_CLOCK(), .BUS_A_OUTPUT_CLOCK(clk_a), .BUS_B_OUTPUT_CLOCK(), .LVDS_SELECT(lvds),
        .LVDS_LOW_POWER(lowp), .STABILIZER_ON(stab), .STABILIZER_LOCKED(locked), .DITHER_VALUE(dither)
    );
    capture_receiver cap_u
    (
        .clock_a(clk_a), .descramble(scr), .bus_a(bus_a), .bus_b(bus_b), .captured_a(cap_a),
        .captured_b(cap_b), .captures(captures)
    );

    // ======================================================================
    // Clocks; the strobe is 320 ns and data moves mid low phase, clear of the sampling edge
    always #20 clock = ~clock;
    always @(posedge clock)
    begin
        phase  <= phase + 3'h1;
        strobe <= run ? phase[2] : strobe;
        if (run && counting && phase == 3'h2)
            result <= result + 16'h0001;
    end

    // ======================================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] expected, input logic [31:0] seen);
        checked++;
        if (seen !== expected)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, expected, seen);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle
    task automatic set_pins(input logic [1:0] m, input logic [1:0] f, input logic s, input logic o);
        @(posedge clock);
        mode <= m;
        fmt  <= f;
        scr  <= s;
        ovr  <= o;
        settle(64);
    endtask : set_pins
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clock);
        wr    <= 1'h0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock);
        rd   <= 1'h0;
        @(negedge clock);
        d = rdata;
    endtask : reg_read
    function automatic logic [15:0] shape(input logic [15:0] v, input logic [1:0] f, input logic s);
        logic [15:0] w;
        w = f[1] ? v ^ 16'h8000 : v;
        return s ? w ^ {{15{w[0]}}, 1'h0} : w;
    endfunction : shape
    task automatic end_of_test;
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // ======================================================================
    // Scenarios
    initial
    begin
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        run  <= 1'h1;
        reg_read(4'h0, rv);
        check("ctrl reset", 32'h0, rv);
        reg_read(4'h2, rv);
        check("unmapped", 32'h0, rv);
        for (int i = 0; i < 8; i++)
        begin
            set_pins(2'h0, i[1:0], i[2], 1'h0);
            check("bus a", shape(16'h1235, i[1:0], i[2]), bus_a);
            check("captured", shape(16'h1235, i[1:0], 1'h0), cap_a);
            check("bus b idle", 32'h0, bus_b);
            check("stabilizer", i[1:0] == 2'h1 || i[1:0] == 2'h2, stab);
        end
        set_pins(2'h0, 2'h0, 1'h1, 1'h1);
        check("flag a", 32'h1, overflow_flag_bus_a);
        check("flag b", 32'h0, overflow_flag_bus_b);
        check("lvds flag", 32'h0, ofl);
        set_pins(2'h3, 2'h0, 1'h0, 1'h1);
        check("lvds flag", 32'h1, ofl);
        check("lvds std", 32'h2, {lvds, lowp});
        set_pins(2'h2, 2'h0, 1'h0, 1'h0);
        check("lvds low", 32'h3, {lvds, lowp});
        reg_read(4'h4, rv);
        check("status", 32'h5, rv & 32'h5);
        check("irq masked", 32'h0, irq);
        reg_write(4'h8, 32'h1);
        settle(2);
        check("irq", 32'h1, irq);
        reg_write(4'h4, 32'h1);
        settle(2);
        check("irq clear", 32'h0, irq);
        counting <= 1'h1;
        set_pins(2'h1, 2'h0, 1'h0, 1'h0);
        c0 = captures;
        settle(64);
        check("half rate", 32'h4, captures - c0);
        check("pair", cap_a + 32'h1, cap_b);
        check("bus pair", bus_a + 32'h1, bus_b);
        counting <= 1'h0;
        reg_write(4'h0, 32'h1);
        settle(32);
        check("dither on", 32'h1, dither != 16'h0);
        reg_write(4'h0, 32'h0);
        settle(32);
        check("dither off", 32'h0, dither);
        set_pins(2'h0, 2'h1, 1'h0, 1'h0);
        settle(880);
        check("locked", 32'h1, locked);
        reg_read(4'hc, rv);
        check("state", 32'h64, rv);
        run <= 1'h0;
        settle(80);
        check("lock lost", 32'h0, locked);
        run <= 1'h1;
        settle(760);
        check("relocking", 32'h0, locked);
        settle(80);
        check("relocked", 32'h1, locked);
        reg_read(4'h4, rv);
        check("lock events", 32'h18, rv & 32'h18);
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
endmodule : test_adc_output_formatter

bind adc_output_formatter adc_output_formatter_checker chk_u
(
    .CLOCK(CLOCK), .NRST(NRST), .SAMPLE_STROBE_INPUT(SAMPLE_STROBE_INPUT), .OUTPUT_MODE_PIN(OUTPUT_MODE_PIN),
    .FORMAT_PIN(FORMAT_PIN), .BUS_A_DATA(BUS_A_DATA), .BUS_B_DATA(BUS_B_DATA), .OVERFLOW_FLAG(OVERFLOW_FLAG),
    .OVERFLOW_FLAG_BUS_A(OVERFLOW_FLAG_BUS_A), .FORWARDED_SAMPLE_CLOCK(FORWARDED_SAMPLE_CLOCK),
    .BUS_A_OUTPUT_CLOCK(BUS_A_OUTPUT_CLOCK), .BUS_B_OUTPUT_CLOCK(BUS_B_OUTPUT_CLOCK), .LVDS_SELECT(LVDS_SELECT),
    .LVDS_LOW_POWER(LVDS_LOW_POWER), .STABILIZER_ON(STABILIZER_ON)
);
